// ===== mbwd_pkg.sv
// Purpose: Shared constants and types for the write and diagnostic handler
// Assumes: Framing and check field handled outside
// Notes:   Offsets are word offsets in the output image
package mbwd_pkg;

    // -------------------------------------------------------------------
    // Function codes and exceptions
    // -------------------------------------------------------------------
    localparam logic [7:0]  FC_WRITE_ONE   = 8'h06;
    localparam logic [7:0]  FC_DIAG        = 8'h08;
    localparam logic [7:0]  FC_WRITE_MANY  = 8'h10;
    localparam logic [7:0]  EXC_FLAG       = 8'h80;
    localparam logic [7:0]  EXC_FUNC       = 8'h01;
    localparam logic [7:0]  EXC_ADDR       = 8'h02;
    localparam logic [7:0]  EXC_VALUE      = 8'h03;
    localparam logic [7:0]  EXC_DEVICE     = 8'h04;
    localparam logic [7:0]  BCAST_ADDR     = 8'h00;

    // -------------------------------------------------------------------
    // Output image window
    // -------------------------------------------------------------------
    localparam logic [15:0] OUT_BASE       = 16'h0800;
    localparam logic [15:0] OUT_LAST       = 16'h08ff;

    // -------------------------------------------------------------------
    // Diagnostic subfunctions
    // -------------------------------------------------------------------
    localparam logic [15:0] SUB_ECHO       = 16'h0000;
    localparam logic [15:0] SUB_RESTART    = 16'h0001;
    localparam logic [15:0] SUB_CLEAR      = 16'h000a;
    localparam logic [15:0] SUB_BUS_MSG    = 16'h000b;
    localparam logic [15:0] SUB_CRC_ERR    = 16'h000c;
    localparam logic [15:0] SUB_EXC_CNT    = 16'h000d;
    localparam logic [15:0] SUB_SLV_MSG    = 16'h000e;
    localparam logic [15:0] SUB_NO_RESP    = 16'h000f;
    localparam logic [15:0] SUB_SLV_EXC    = 16'h0010;

    // -------------------------------------------------------------------
    // Timing and reset values
    // -------------------------------------------------------------------
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          RESTART_US     = 100;
    localparam logic [11:0] RESTART_CYC    = 12'(RESTART_US * (CLK_HZ / 1_000_000));
    localparam logic [15:0] CNT_RST        = 16'h0000;

    typedef enum logic [3:0] {
        ST_ADDR, ST_FUNC, ST_H1, ST_L1, ST_H2, ST_L2, ST_BCNT, ST_DH, ST_DL,
        ST_SKIP, ST_EXEC, ST_TX, ST_RESTART
    } mbwd_state_t;

endpackage : mbwd_pkg

// ===== mbwd_counters.sv
// Purpose: Diagnostic event counters
// Assumes: Event pulses are one cycle wide
// Notes:   Saturating at all ones
`timescale 1ns/100ps
module mbwd_counters
    import mbwd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Events
    input  wire logic        clr,
    input  wire logic [4:0]  evt,
    // Counter readout
    input  wire logic [2:0]  sel,
    output logic      [15:0] value
);
    typedef struct packed {
        logic [4:0][15:0] cnt;
    } mbwd_cnt_t;

    mbwd_cnt_t cur_r;
    mbwd_cnt_t cur_nxt;

    // Increment or clear
    always_comb begin
        cur_nxt = cur_r;
        for (int i = 0; i < 5; i++) begin
            if (clr) begin
                cur_nxt.cnt[i] = CNT_RST;
            end else if (evt[i] && cur_r.cnt[i] != 16'hffff) begin
                cur_nxt.cnt[i] = cur_r.cnt[i] + 16'h0001;
            end
        end
    end

    // Register state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_r <= '0;
        end else if (ce) begin
            cur_r <= cur_nxt;
        end
    end

    assign value = (sel < 3'd5) ? cur_r.cnt[sel] : 16'h0000;

endmodule : mbwd_counters

// ===== mbwd_handler.sv
// Purpose: Slave handler for single write, multi write and diagnostics
// Assumes: Check field validated upstream
// Notes:   Replies go out one byte per cycle on tx_valid/tx_ready
// Operation
// R1: Output image words addressed from offset 0x0800, one word per step.
// R2: Single write is addr, 0x06, offset hi/lo, data hi/lo.
// R3: Single write reply mirrors the request.
// R4: Diagnostics 0x08 carry subfunction and data; reply returns both codes.
// R5: Broadcast diagnostics are ignored.
// R6: Subfunction 0 echoes the request data.
// R7: Subfunction 1 restarts, clears counters, blocks rx and tx meanwhile.
// R8: Subfunction 1 reply goes out before restart; data zero.
// R9: On the RS232 variant, other subfunctions return zero.
// R10: Clear subfunction zeroes counters and echoes the data.
// R11: Bus message subfunction returns the answer count.
// R12: Check field errors are counted and reported.
// R13: Exception replies are counted, subfunction 13 reports it.
// R14: Every reply is counted, subfunction 14 reports it.
// R15: Unanswered requests are counted, subfunction 15 reports it.
// R16: Error answers are counted, subfunction 16 reports it.
// R17: Multi write gives offset, word length, byte count, then words.
// R18: Multi write reply holds function, offset and length only.
// R19: Byte count not twice length gives illegal data value exception.
// R20: All 16-bit fields travel high byte first.
// R21: Exception reply is function plus 0x80 and one code byte.
// R22: Exception codes 1 function, 2 address, 3 value, 4 device fault.
// R23: Write offsets outside 0x800 to 0x8FF are refused.
`timescale 1ns/100ps
module mbwd_handler
    import mbwd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Configuration
    input  wire logic [7:0]  slave_addr,
    input  wire logic        rs232_variant,
    input  wire logic        device_fault,
    // Request byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_end,
    input  wire logic        rx_crc_err,
    output logic             rx_ready,
    // Reply byte stream
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    // Output image write port
    output logic             img_we,
    output logic [7:0]       img_idx,
    output logic [15:0]      img_wdata,
    // Restart in progress
    output logic             restart_busy
);
    typedef struct packed {
        mbwd_state_t st;
        logic [7:0]  addr;
        logic [7:0]  func;
        logic [15:0] f1;
        logic [15:0] f2;
        logic [7:0]  bcnt;
        logic [7:0]  hi;
        logic [7:0]  widx;
        logic [7:0]  nwr;
        logic        bad;
        logic [7:0]  exc;
        logic [7:0][7:0] txb;
        logic [2:0]  txn;
        logic [2:0]  txp;
        logic        do_restart;
        logic [11:0] rcnt;
        logic        rx_ready;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        tx_last;
        logic        img_we;
        logic [7:0]  img_idx;
        logic [15:0] img_wdata;
        logic        busy;
    } mbwd_state_s_t;

    mbwd_state_s_t s_r;
    mbwd_state_s_t s_nxt;
    logic [4:0]    evt;
    logic          cnt_clr;
    logic [2:0]    cnt_sel;
    logic [15:0]   cnt_val;

    // Offset inside output window
    function automatic logic in_window(input logic [15:0] off);
        return off >= OUT_BASE && off <= OUT_LAST;
    endfunction : in_window

    // High byte of a word
    function automatic logic [7:0] hb(input logic [15:0] w);
        return w[15:8];
    endfunction : hb

    // Counter select: 0 bus msg, 1 crc, 2 exc, 3 slave msg, 4 no resp
    always_comb begin
        case (s_r.f1)
            SUB_BUS_MSG: cnt_sel = 3'd0;
            SUB_CRC_ERR: cnt_sel = 3'd1;
            SUB_EXC_CNT: cnt_sel = 3'd2;
            SUB_SLV_MSG: cnt_sel = 3'd3;
            SUB_SLV_EXC: cnt_sel = 3'd2;
            SUB_NO_RESP: cnt_sel = 3'd4;
            default:     cnt_sel = 3'd7;
        endcase
    end

    mbwd_counters u_cnt (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .clr   (cnt_clr),
        .evt   (evt),
        .sel   (cnt_sel),
        .value (cnt_val)
    );

    // Main sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.img_we = 1'b0;
        evt = 5'b0;
        cnt_clr = 1'b0;
        s_nxt.rx_ready = (s_r.st != ST_EXEC) && (s_r.st != ST_TX) && (s_r.st != ST_RESTART);
        if (rx_valid && s_r.rx_ready && rx_end && rx_crc_err) begin
            evt[1] = 1'b1; // see R12
            s_nxt.st = ST_ADDR;
        end else begin
            case (s_r.st)
                ST_ADDR: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.addr = rx_data;
                    s_nxt.bad = 1'b0;
                    s_nxt.exc = 8'h00;
                    s_nxt.nwr = 8'h00;
                    s_nxt.st = (rx_data == slave_addr || rx_data == BCAST_ADDR) ? ST_FUNC
                                                                              : ST_SKIP;
                end
                ST_FUNC: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.func = rx_data;
                    if (rx_data == FC_WRITE_ONE || rx_data == FC_WRITE_MANY ||
                        rx_data == FC_DIAG) begin
                        s_nxt.st = ST_H1;
                    end else begin
                        s_nxt.exc = EXC_FUNC; // see R22
                        s_nxt.st = ST_SKIP;
                    end
                end
                // Fields high byte first
                ST_H1: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.hi = rx_data; // see R20
                    s_nxt.st = ST_L1;
                end
                ST_L1: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.f1 = {s_r.hi, rx_data};
                    s_nxt.st = ST_H2;
                end
                ST_H2: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.hi = rx_data;
                    s_nxt.st = ST_L2;
                end
                ST_L2: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.f2 = {s_r.hi, rx_data}; // see R2 R4 R17
                    s_nxt.widx = 8'(s_r.f1 - OUT_BASE); // see R1
                    s_nxt.st = (s_r.func == FC_WRITE_MANY) ? ST_BCNT :
                               rx_end ? ST_EXEC : ST_SKIP;
                end
                ST_BCNT: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.bcnt = rx_data;
                    if ({8'h00, rx_data} != {s_r.f2[14:0], 1'b0}) begin
                        s_nxt.exc = EXC_VALUE; // see R19
                        s_nxt.st = ST_SKIP;
                    end else begin
                        s_nxt.st = ST_DH;
                    end
                end
                ST_DH: if (rx_valid && s_r.rx_ready) begin
                    s_nxt.hi = rx_data;
                    s_nxt.st = ST_DL;
                end
                // Write words if range good
                ST_DL: if (rx_valid && s_r.rx_ready) begin
                    if (in_window(s_r.f1) && in_window(s_r.f1 + s_r.f2 - 16'h0001) &&
                        s_r.f2 != 16'h0000 && !device_fault) begin
                        s_nxt.img_we = 1'b1; // see R1
                        s_nxt.img_idx = s_r.widx;
                        s_nxt.img_wdata = {s_r.hi, rx_data};
                    end
                    s_nxt.widx = s_r.widx + 8'h01;
                    s_nxt.nwr = s_r.nwr + 8'h01;
                    s_nxt.st = (s_r.nwr + 8'h01 != s_r.f2[7:0]) ? ST_DH :
                               rx_end ? ST_EXEC : ST_SKIP;
                end
                ST_SKIP: if (rx_valid && s_r.rx_ready && rx_end) begin
                    s_nxt.st = (s_r.addr == slave_addr || s_r.addr == BCAST_ADDR) ? ST_EXEC
                                                                                 : ST_ADDR;
                end
                ST_EXEC: begin
                    s_nxt.txb = '0;
                    s_nxt.txp = 3'd0;
                    s_nxt.do_restart = 1'b0;
                    if (s_r.exc == 8'h00 && s_r.func != FC_DIAG) begin
                        if (!in_window(s_r.f1) || (s_r.func == FC_WRITE_MANY &&
                            !in_window(s_r.f1 + s_r.f2 - 16'h0001))) begin
                            s_nxt.exc = EXC_ADDR; // see R23
                        end else if (device_fault) begin
                            s_nxt.exc = EXC_DEVICE;
                        end else if (s_r.func == FC_WRITE_ONE) begin
                            s_nxt.img_we = 1'b1; // see R1 R2
                            s_nxt.img_idx = 8'(s_r.f1 - OUT_BASE);
                            s_nxt.img_wdata = s_r.f2;
                        end
                    end
                    s_nxt.st = ST_TX;
                    if (s_r.addr == BCAST_ADDR) begin
                        evt[4] = 1'b1; // see R5 R15
                        s_nxt.st = ST_ADDR;
                    end
                end
                ST_TX: begin
                    if (s_r.txp == 3'd0 && !s_r.tx_valid) begin
                        // Build reply once
                        s_nxt.txb[0] = s_r.addr;
                        if (s_r.exc != 8'h00) begin
                            s_nxt.txb[1] = s_r.func | EXC_FLAG; // see R21
                            s_nxt.txb[2] = s_r.exc;
                            s_nxt.txn = 3'd3;
                        end else begin
                            s_nxt.txb[1] = s_r.func;
                            s_nxt.txb[2] = hb(s_r.f1);
                            s_nxt.txb[3] = s_r.f1[7:0];
                            s_nxt.txb[4] = hb(s_r.f2); // see R3 R18
                            s_nxt.txb[5] = s_r.f2[7:0];
                            s_nxt.txn = 3'd6;
                            if (s_r.func == FC_DIAG) begin
                                case (s_r.f1)
                                    SUB_ECHO: ; // see R6
                                    SUB_RESTART: begin
                                        s_nxt.txb[4] = 8'h00; // see R8
                                        s_nxt.txb[5] = 8'h00;
                                        s_nxt.do_restart = 1'b1;
                                    end
                                    SUB_CLEAR: cnt_clr = 1'b1; // see R10
                                    default: begin
                                        s_nxt.txb[4] = rs232_variant ? 8'h00 : hb(cnt_val);
                                        s_nxt.txb[5] = rs232_variant ? 8'h00 : cnt_val[7:0];
                                    end // see R9 R11 R13 R14 R16
                                endcase
                            end
                        end
                        s_nxt.tx_valid = 1'b1;
                        s_nxt.tx_data = s_r.addr;
                        s_nxt.tx_last = 1'b0;
                    end else if (s_r.tx_valid && tx_ready) begin
                        if (s_r.tx_last) begin
                            s_nxt.tx_valid = 1'b0;
                            s_nxt.tx_last = 1'b0;
                            evt[0] = 1'b1; // see R11
                            evt[3] = 1'b1; // see R14
                            evt[2] = (s_r.exc != 8'h00); // see R13 R16
                            s_nxt.rcnt = RESTART_CYC;
                            s_nxt.busy = s_r.do_restart;
                            s_nxt.st = s_r.do_restart ? ST_RESTART : ST_ADDR; // see R8
                        end else begin
                            s_nxt.txp = s_r.txp + 3'd1;
                            s_nxt.tx_data = s_r.txb[s_r.txp + 3'd1];
                            s_nxt.tx_last = (s_r.txp + 3'd2 == s_r.txn);
                        end
                    end
                end
                // Restart with counter clear, no traffic
                ST_RESTART: begin
                    cnt_clr = 1'b1; // see R7
                    s_nxt.rcnt = s_r.rcnt - 12'h001;
                    if (s_r.rcnt == 12'h001) begin
                        s_nxt.busy = 1'b0;
                        s_nxt.st = ST_ADDR;
                    end
                end
                default: s_nxt.st = ST_ADDR;
            endcase
        end
    end

    // Register state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= ST_ADDR;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rx_ready     = s_r.rx_ready;
    assign tx_valid     = s_r.tx_valid;
    assign tx_data      = s_r.tx_data;
    assign tx_last      = s_r.tx_last;
    assign img_we       = s_r.img_we;
    assign img_idx      = s_r.img_idx;
    assign img_wdata    = s_r.img_wdata;
    assign restart_busy = s_r.busy;

endmodule : mbwd_handler

// ===== mbwd_handler_assertions.sv
// Purpose: Port level checks for the write and diagnostic handler
// Assumes: One clock, sync reset
// Notes:   Tracks byte position in a reply
`timescale 1ns/100ps
module mbwd_handler_assertions
    import mbwd_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic [7:0] slave_addr,
    // Request and reply streams
    input wire logic       rx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       tx_ready,
    // Image and restart
    input wire logic       img_we,
    input wire logic       restart_busy
);
    // ---------------------------------------------------------------
    // Reply byte tracking
    // ---------------------------------------------------------------
    logic [2:0] idx_r;
    logic       exc_r;

    // Byte index and exception flag of reply
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_r <= 3'h0;
            exc_r <= 1'b0;
        end else if (ce && tx_valid && tx_ready) begin
            idx_r <= tx_last ? 3'h0 : idx_r + 3'h1;
            if (idx_r == 3'h1) begin
                exc_r <= tx_data[7];
            end
        end
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_QUIET_RESTART: assert property (restart_busy |-> !rx_ready && !tx_valid)
        else $error("Busy traffic");
    AST_RESTART_HOLD: assert property ($rose(restart_busy) |-> restart_busy [*8])
        else $error("Short restart");
    AST_REPLY_BEFORE: assert property ($rose(restart_busy) |-> idx_r == 3'h0 && !tx_valid)
        else $error("Restart in reply");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("Byte not held");
    AST_ADDR_FIRST: assert property (tx_valid && idx_r == 3'h0 |-> tx_data == slave_addr)
        else $error("Bad first byte");
    AST_EXC_FRAME: assert property (tx_valid && idx_r == 3'h2 && exc_r |-> tx_last && tx_data inside {[8'h01:8'h04]})
        else $error("Bad exception");
    AST_NORMAL_LEN: assert property (tx_valid && idx_r > 3'h1 && !exc_r |-> tx_last == (idx_r == 3'h5))
        else $error("Bad reply length");
    AST_IMG_PULSE: assert property (img_we |-> !tx_valid ##1 !img_we)
        else $error("Bad image write");
    AST_TX_NO_RX: assert property (tx_valid |-> !rx_ready)
        else $error("Rx in reply");
endmodule : mbwd_handler_assertions

bind mbwd_handler mbwd_handler_assertions i_mbwd_handler_assertions (.*);

// ===== mbwd_master_model.sv
// Purpose: Bus master model: requests out, replies in
// Assumes: Frames stripped of framing and check
// Notes:   Sink may stall
`timescale 1ns/100ps
module mbwd_master_model
(
    // Clock
    input  wire logic       clk,
    // Request byte stream
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    output logic            rx_crc_err,
    input  wire logic       rx_ready,
    // Reply byte stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] rsp_q[$];
    logic       stall;
    int         n_rsp;

    // Idle levels at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_end = 1'b0;
        rx_crc_err = 1'b0;
        stall = 1'b0;
        n_rsp = 0;
    end

    // Send frame, each byte held until taken
    task automatic send(input logic [7:0] fr[$], input logic bad);
        for (int i = 0; i < fr.size(); i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data = fr[i];
            rx_end = (i == fr.size() - 1);
            rx_crc_err = bad && rx_end;
            while (!rx_ready) @(negedge clk);
            @(posedge clk);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_crc_err = 1'b0;
        rx_data = ~rx_data; // No stale byte
    endtask : send

    // Reply sink, optionally slow
    always @(negedge clk) begin
        tx_ready <= stall ? ~tx_ready : 1'b1;
    end

    // Collect accepted reply bytes
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready) begin
            rsp_q.push_back(tx_data);
            if (tx_last) n_rsp <= n_rsp + 1;
        end
    end
endmodule : mbwd_master_model

// ===== mbwd_handler_tb_top.sv
// Purpose: Self checking bench for the handler
// Assumes: Own address 0x0b, clock enable held high
// Notes:   Reply counters checked relatively
`timescale 1ns/100ps
module mbwd_handler_tb_top
    import mbwd_pkg::*;
    ;
    typedef logic [7:0] mbwd_bytes_t[$];
    logic        clk, rst_n, ce, rs232_variant, device_fault;
    logic [7:0]  slave_addr, rx_data, tx_data, img_idx;
    logic        rx_valid, rx_end, rx_crc_err, rx_ready, tx_valid, tx_last, tx_ready;
    logic        img_we, restart_busy;
    logic [15:0] img_wdata, v, w;
    logic [23:0] wq[$];
    int          n_fail = 0;
    int          num_checks = 0;

    // ---------------------------------------------------------------
    // Instances
    // ---------------------------------------------------------------
    mbwd_handler i_mbwd_handler (.clk(clk), .rst_n(rst_n), .ce(ce), .slave_addr(slave_addr),
        .rs232_variant(rs232_variant), .device_fault(device_fault), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_end(rx_end), .rx_crc_err(rx_crc_err), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .img_we(img_we), .img_idx(img_idx), .img_wdata(img_wdata), .restart_busy(restart_busy));
    mbwd_master_model i_master (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_end(rx_end), .rx_crc_err(rx_crc_err), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

    // Clock and image write log
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (img_we === 1'b1) wq.push_back({img_idx, img_wdata});
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic txn(input mbwd_bytes_t fr, input logic bad, input mbwd_bytes_t exp,
                       input logic full);
        int n0;
        n0 = i_master.n_rsp;
        i_master.rsp_q.delete();
        i_master.send(fr, bad);
        for (int i = 0; i < (exp.size() ? 300 : 40) && i_master.n_rsp == n0; i++) @(negedge clk);
        if (full) chk("reply_len", 24'(exp.size()), 24'(i_master.rsp_q.size()));
        foreach (exp[i]) chk("reply_byte", 24'(exp[i]), 24'(i_master.rsp_q[i]));
    endtask : txn

    task automatic rd(input logic [15:0] sub, output logic [15:0] val);
        txn('{8'h0b, FC_DIAG, sub[15:8], sub[7:0], 8'h00, 8'h00}, 1'b0,
            '{8'h0b, FC_DIAG, sub[15:8], sub[7:0]}, 1'b0);
        chk("reply_len", 24'h6, 24'(i_master.rsp_q.size()));
        val = {i_master.rsp_q[4], i_master.rsp_q[5]};
    endtask : rd

    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_writes();
        wq.delete();
        txn('{8'h0b, 8'h06, 8'h08, 8'h03, 8'h3f, 8'hff}, 1'b0,
            '{8'h0b, 8'h06, 8'h08, 8'h03, 8'h3f, 8'hff}, 1'b1);
        chk("img_write", 24'h033fff, wq[0]);
        i_master.stall = 1'b1;
        txn('{8'h0b, 8'h10, 8'h08, 8'h00, 8'h00, 8'h02, 8'h04, 8'h7f, 8'hff, 8'h3f, 8'hff},
            1'b0, '{8'h0b, 8'h10, 8'h08, 8'h00, 8'h00, 8'h02}, 1'b1);
        i_master.stall = 1'b0;
        chk("img_count", 24'h3, 24'(wq.size()));
        chk("img_write", 24'h007fff, wq[1]);
        chk("img_write", 24'h013fff, wq[2]);
    endtask : t_writes

    task automatic t_errors();
        wq.delete();
        txn('{8'h0b, 8'h10, 8'h08, 8'h00, 8'h00, 8'h02, 8'h02, 8'h7f, 8'hff}, 1'b0,
            '{8'h0b, 8'h90, EXC_VALUE}, 1'b1);
        txn('{8'h0b, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0,
            '{8'h0b, 8'h83, EXC_FUNC}, 1'b1);
        txn('{8'h0b, 8'h06, 8'h09, 8'h00, 8'h12, 8'h34}, 1'b0,
            '{8'h0b, 8'h86, EXC_ADDR}, 1'b1);
        device_fault = 1'b1;
        txn('{8'h0b, 8'h06, 8'h08, 8'h00, 8'h12, 8'h34}, 1'b0,
            '{8'h0b, 8'h86, EXC_DEVICE}, 1'b1);
        device_fault = 1'b0;
        chk("img_count", 24'h0, 24'(wq.size()));
    endtask : t_errors

    task automatic t_diag();
        txn('{8'h0b, 8'h08, 8'h00, 8'h00, 8'h02, 8'h03}, 1'b0,
            '{8'h0b, 8'h08, 8'h00, 8'h00, 8'h02, 8'h03}, 1'b1);
        txn('{8'h00, 8'h08, 8'h00, 8'h00, 8'h02, 8'h03}, 1'b0, '{}, 1'b1);
        rd(SUB_EXC_CNT, v);
        chk("exc_count", 24'h4, 24'(v));
        rd(SUB_SLV_EXC, v);
        chk("err_answers", 24'h4, 24'(v));
        rd(SUB_NO_RESP, v);
        chk("unanswered", 24'h1, 24'(v));
        rd(SUB_SLV_MSG, v);
        rd(SUB_SLV_MSG, w);
        chk("reply_count", 24'(v + 16'h1), 24'(w));
        rd(SUB_BUS_MSG, v);
        rd(SUB_BUS_MSG, w);
        chk("answer_count", 24'(v + 16'h1), 24'(w));
        rs232_variant = 1'b1;
        rd(SUB_EXC_CNT, v);
        chk("rs232_zero", 24'h0, 24'(v));
        rs232_variant = 1'b0;
        txn('{8'h0b, 8'h08, 8'h00, 8'h00, 8'h02, 8'h03}, 1'b1, '{}, 1'b1);
        rd(SUB_CRC_ERR, v);
        chk("crc_count", 24'h1, 24'(v));
        txn('{8'h0b, 8'h08, 8'h00, 8'h0a, 8'h00, 8'h00}, 1'b0,
            '{8'h0b, 8'h08, 8'h00, 8'h0a, 8'h00, 8'h00}, 1'b1);
        rd(SUB_EXC_CNT, v);
        chk("exc_cleared", 24'h0, 24'(v));
        rd(SUB_CRC_ERR, v);
        chk("crc_cleared", 24'h0, 24'(v));
    endtask : t_diag

    task automatic t_restart();
        int n = 0;
        txn('{8'h0b, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0,
            '{8'h0b, 8'h83, EXC_FUNC}, 1'b1);
        txn('{8'h0b, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00}, 1'b0,
            '{8'h0b, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00}, 1'b1);
        for (int i = 0; i < 20 && restart_busy !== 1'b1; i++) @(negedge clk);
        chk("restart_busy", 24'h1, 24'(restart_busy));
        chk("rx_ready_busy", 24'h0, 24'(rx_ready));
        while (restart_busy === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("restart_span", 24'h1, 24'(n > int'(RESTART_CYC) - 30 && n <= int'(RESTART_CYC)));
        rd(SUB_EXC_CNT, v);
        chk("exc_after_restart", 24'h0, 24'(v));
    endtask : t_restart

    // Main sequence
    initial begin
        ce = 1'b1;
        slave_addr = 8'h0b;
        rs232_variant = 1'b0;
        device_fault = 1'b0;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_writes();
        t_errors();
        t_diag();
        t_restart();
        end_of_test();
    end

    // Watchdog
    initial begin
        #2_000_000;
        n_fail++;
        end_of_test();
    end
endmodule : mbwd_handler_tb_top
